// ---- cmw_pkg.sv ----
// Constants for the card memory window end-address and offset register bank.
// Overview of operation
// R1: Add wait states equal to bits 7-6 to each 16-bit window access.
// R2: End-high bits 5-4 read zero and ignore writes.
// R3: End-high bits 3-0 give end address A23-A20 for window decode.
// R4: Offset-low byte gives offset A19-A12, added in host-to-card translation.
// R5: Window 0 end-high sits at socket offset 813h; windows step by 8h.
// R6: Each offset-low register sits one byte above its end-high register.
// R7: End-low byte gives end A19-A12, forming the 12-bit compared end address.
// R8: Offset-high bits 5-0 give offset A25-A20 above the low byte.
// R9: Reset clears all end-high and offset-low registers of both sockets.
`default_nettype none
package cmw_pkg;
	localparam int          NUM_WIN        = 5;
	localparam int          NUM_CARD       = 2;
	localparam logic [11:0] WIN0_END_HI    = 12'h813;
	localparam logic [11:0] WIN1_END_HI    = 12'h81b;
	localparam logic [11:0] WIN1_OFF_LO    = 12'h81c;
	localparam logic [11:0] WIN2_END_HI    = 12'h823;
	localparam logic [11:0] WIN2_OFF_LO    = 12'h824;
	localparam logic [11:0] WIN3_END_HI    = 12'h82b;
	localparam logic [11:0] WIN3_OFF_LO    = 12'h82c;
	localparam logic [11:0] WIN4_END_HI    = 12'h833;
	localparam logic [11:0] WIN4_OFF_LO    = 12'h834;
	localparam logic [11:0] WIN0_OFF_LO    = 12'h814;
	localparam logic [7:0]  WIN_STRIDE     = 8'h08;
	localparam logic [3:0]  LEGACY_PAGE    = 4'h8;
	localparam logic [7:0]  CARD_A_BASE    = 8'h13;
	localparam logic [7:0]  CARD_B_BASE    = 8'h53;
	localparam int          WAIT_MSB       = 7;
	localparam int          WAIT_LSB       = 6;
	localparam int          NIBBLE_MSB     = 3;
	localparam logic [7:0]  END_HI_RESET   = 8'h00;
	localparam logic [7:0]  OFF_LO_RESET   = 8'h00;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          ISA_WS_NS      = 120;
	localparam int          ISA_WS_CYCLES  = (ISA_WS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		CMW_IDLE = 3'b001,
		CMW_WAIT = 3'b010,
		CMW_DONE = 3'b100
	} cmw_state_e;
endpackage
`default_nettype wire

// ---- cmw_regs.sv ----
// Per-socket end-address high-nibble, wait-state and offset low-byte registers with window access timing.
`timescale 1ns/100ps
`default_nettype none
module cmw_regs #(
	parameter int WS_CYCLES = cmw_pkg::ISA_WS_CYCLES
) (
	input  wire logic                                                clk,
	input  wire logic                                                rst,
	input  wire logic                                                reg_wr,
	input  wire logic                                                reg_rd,
	input  wire logic                                                reg_card,
	input  wire logic [11:0]                                         reg_addr,
	input  wire logic [7:0]                                          reg_wdata,
	output logic [7:0]                                               reg_rdata,
	input  wire logic [cmw_pkg::NUM_CARD-1:0][cmw_pkg::NUM_WIN-1:0][11:0] win_start,
	input  wire logic [cmw_pkg::NUM_CARD-1:0][cmw_pkg::NUM_WIN-1:0][7:0]  win_end_lo,
	input  wire logic [cmw_pkg::NUM_CARD-1:0][cmw_pkg::NUM_WIN-1:0][5:0]  offset_addr_top_bits,
	input  wire logic                                                acc_req,
	input  wire logic                                                acc_card,
	input  wire logic                                                acc_wide,
	input  wire logic [11:0]                                         acc_page,
	output logic                                                     acc_busy,
	output logic                                                     acc_done,
	output logic                                                     acc_hit,
	output logic [2:0]                                               acc_win,
	output logic [13:0]                                              acc_card_page
);
	import cmw_pkg::*;

	localparam int CW = $clog2(3 * WS_CYCLES + 2);

	// Register storage: end-high keeps only its live bits; reserved bits are never stored.
	logic [NUM_CARD-1:0][NUM_WIN-1:0][1:0] window_wait_count;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][3:0] end_addr_top_nibble;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][7:0] off_lo;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][7:0] end_hi_view;
	cmw_state_e                             state;
	cmw_state_e                             next_state;
	logic [CW-1:0]                          wait_cnt;
	logic [CW-1:0]                          next_wait_cnt;

	// Decode a socket offset into window index and register kind (0 end-high, 1 offset-low).
	function automatic logic [4:0] decode_reg(input logic [11:0] addr);
		logic [7:0] rel;
		logic       ok;
		rel = addr[7:0] - WIN0_END_HI[7:0]; // R5
		ok = (addr[11:8] == LEGACY_PAGE) && (rel[2:1] == 2'b00) && (rel[7:3] < 5'(NUM_WIN)); // R5 R6
		return {ok, rel[5:3], rel[0]};
	endfunction

	wire logic [4:0] dec      = decode_reg(reg_addr);
	wire logic       dec_ok   = dec[4];
	wire logic [2:0] dec_win  = dec[3:1];
	wire logic       dec_off  = dec[0];
	wire logic [7:0] rd_end   = end_hi_view[reg_card][dec_win];
	wire logic [7:0] rd_off   = off_lo[reg_card][dec_win];
	wire logic [7:0] rd_value = !dec_ok ? 8'h00 : (dec_off ? rd_off : rd_end);
	wire logic       wr_end   = reg_wr && dec_ok && !dec_off;
	wire logic       wr_off   = reg_wr && dec_ok && dec_off;

	// Read view of end-high: reserved bits 5-4 are tied to zero.
	always_comb begin
		for (int c = 0; c < NUM_CARD; c++) begin
			for (int w = 0; w < NUM_WIN; w++) begin
				end_hi_view[c][w] = {window_wait_count[c][w], 2'b00, end_addr_top_nibble[c][w]}; // R2
			end
		end
	end

	// Register writes; the bits 5-4 of write data are dropped on purpose.
	always_ff @(posedge clk) begin
		if (rst) begin
			window_wait_count <= '0; // R9
			end_addr_top_nibble <= '0; // R9
			off_lo <= '0; // R9
		end else begin
			if (wr_end) begin
				window_wait_count[reg_card][dec_win] <= reg_wdata[WAIT_MSB:WAIT_LSB]; // R1
				end_addr_top_nibble[reg_card][dec_win] <= reg_wdata[NIBBLE_MSB:0]; // R2 R3
			end
			if (wr_off) begin
				off_lo[reg_card][dec_win] <= reg_wdata; // R4
			end
		end
	end

	// Read data is registered so the output comes straight from a flip-flop; unmapped reads give zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_value;
		end
	end

	// Window search for the card named by the access.
	logic        m_hit;
	logic [2:0]  m_win;
	logic [13:0] m_page;
	logic [1:0]  m_ws;

	cmw_win_match u_match (
		.host_page  (acc_page),
		.start_page (win_start[acc_card]),
		.end_hi     (end_hi_view[acc_card]),
		.end_lo     (win_end_lo[acc_card]),
		.off_lo     (off_lo[acc_card]),
		.off_top    (offset_addr_top_bits[acc_card]),
		.hit        (m_hit),
		.win        (m_win),
		.card_page  (m_page),
		.wait_count (m_ws)
	);

	// Extra cycles for this access: only 16-bit hits are stretched by the wait-state field.
	wire logic [CW-1:0] ws_len  = CW'(m_ws) * CW'(WS_CYCLES); // R1
	wire logic [CW-1:0] add_len = (m_hit && acc_wide) ? ws_len : '0; // R1
	wire logic          take    = acc_req && (state == CMW_IDLE);

	// Access sequencer: requests made while busy are ignored, busy tells the requester to hold off.
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		unique case (state)
			CMW_IDLE: begin
				if (take) begin
					next_wait_cnt = add_len;
					next_state = (add_len == '0) ? CMW_DONE : CMW_WAIT;
				end
			end
			CMW_WAIT: begin
				next_wait_cnt = wait_cnt - CW'(1); // R1
				if (wait_cnt == CW'(1)) begin
					next_state = CMW_DONE;
				end
			end
			CMW_DONE: begin
				next_state = CMW_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= CMW_IDLE;
			wait_cnt <= '0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
		end
	end

	// Result of the decode is captured when the request is taken and held until the next one.
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_hit <= 1'b0;
			acc_win <= 3'h0;
			acc_card_page <= 14'h0000;
		end else if (take) begin
			acc_hit <= m_hit;
			acc_win <= m_win;
			acc_card_page <= m_page; // R4 R8
		end
	end

	// Status outputs registered from the next state so they line up with the sequencer.
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_busy <= 1'b0;
			acc_done <= 1'b0;
		end else begin
			acc_busy <= (next_state != CMW_IDLE);
			acc_done <= (next_state == CMW_DONE);
		end
	end
endmodule
`default_nettype wire

// ---- cmw_regs_checker.sv ----
// Assertions on the window register bank and its access timing.
`timescale 1ns/100ps
`default_nettype none
module cmw_regs_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_rdata,
	input wire logic        acc_req,
	input wire logic        acc_wide,
	input wire logic        acc_busy,
	input wire logic        acc_done
);
	// One clock domain, so reset disables every check at once.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take; acc_req && !acc_busy; endsequence
	sequence s_end; acc_done ##1 (!acc_done && !acc_busy); endsequence
	a_reserved_zero: assert property (reg_rd && reg_addr[2:0] == 3'h3 |=> reg_rdata[5:4] == 2'h0)
		else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (reg_rd && reg_addr[11:8] != 4'h8 |=> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_take_busy: assert property (s_take |=> acc_busy)
		else $error("accepted access not busy");
	a_narrow_fast: assert property (s_take and !acc_wide |=> acc_done)
		else $error("narrow access was delayed");
	a_done_ends: assert property (acc_done |-> s_end)
		else $error("access did not end after done");
	a_wait_bounded: assert property (s_take |-> ##[1:37] acc_done)
		else $error("access never completed");
	a_reset_clear: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !acc_busy && !acc_done)
		else $error("outputs not clear after reset");
endmodule
bind cmw_regs cmw_regs_checker chk (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_rdata(reg_rdata), .acc_req(acc_req), .acc_wide(acc_wide), .acc_busy(acc_busy), .acc_done(acc_done));
`default_nettype wire

// ---- cmw_regs_tb.sv ----
// Self-checking bench for the window register bank and access timing.
`timescale 1ns/100ps
`default_nettype none
module cmw_regs_tb;
	import cmw_pkg::*;
	localparam int WS = 2;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, card = 1'b0;
	logic areq = 1'b0, acard = 1'b0, wide = 1'b0, busy, done, hit;
	logic [11:0] addr = 12'h000, page = 12'h000;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [2:0]  win;
	logic [13:0] cpage;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][11:0] start = '1;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][7:0]  end_lo = '0;
	logic [NUM_CARD-1:0][NUM_WIN-1:0][5:0]  top = '0;
	int err_count = 0, checks = 0;
	always #5 clk = ~clk;
	cmw_regs #(.WS_CYCLES(WS)) DUT (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_card(card),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .win_start(start), .win_end_lo(end_lo),
		.offset_addr_top_bits(top), .acc_req(areq), .acc_card(acard), .acc_wide(wide), .acc_page(page),
		.acc_busy(busy), .acc_done(done), .acc_hit(hit), .acc_win(win), .acc_card_page(cpage));
	task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// The strobe drops one edge later, so back-to-back calls leave two idle cycles.
	task automatic bus(input logic w, input logic c, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		card <= c;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// Counts edges after the taking edge until done shows; an unstretched access gives zero.
	task automatic acc(input logic c, w, input logic [11:0] p, input int n, input logic h, input logic [13:0] cp);
		int k;
		@(posedge clk);
		areq <= 1'b1;
		acard <= c;
		wide <= w;
		page <= p;
		@(posedge clk);
		areq <= 1'b0;
		#1 k = 0;
		while (done !== 1'b1 && k < 60) begin
			@(posedge clk);
			#1 k++;
		end
		if (k >= 60) begin
			err_count++;
			stop_test();
		end
		chk("done_delay", 14'(n), 14'(k));
		chk("hit", 14'(h), 14'(hit));
		if (h) begin
			chk("win", 14'h2, 14'(win));
			chk("card_page", cp, cpage);
		end
	endtask
	task automatic t_map();
		for (int c = 0; c < 2; c++) for (int n = 0; n < 5; n++) begin
			bus(1'b1, c[0], WIN0_END_HI + 12'(8 * n), {n[1:0], 2'b11, c[0], n[2:0]});
			bus(1'b1, c[0], WIN0_END_HI + 12'(8 * n + 1), {c[0], n[2:0], 4'h5});
		end
		for (int c = 0; c < 2; c++) for (int n = 0; n < 5; n++) begin
			bus(1'b0, c[0], WIN0_END_HI + 12'(8 * n), 8'h00);
			chk("end_high", {n[1:0], 2'b00, c[0], n[2:0]}, rdata);
			bus(1'b0, c[0], WIN0_END_HI + 12'(8 * n + 1), 8'h00);
			chk("offset_low", {c[0], n[2:0], 4'h5}, rdata);
		end
	endtask
	// Neighbouring registers and other pages belong elsewhere and must read as zero.
	task automatic t_unmapped();
		logic [11:0] a[3] = '{12'h812, 12'h835, 12'h013};
		foreach (a[i]) begin
			bus(1'b1, 1'b0, a[i], 8'hff);
			bus(1'b0, 1'b0, a[i], 8'h00);
			chk("unmapped", 14'h0, rdata);
		end
	endtask
	task automatic t_access();
		for (int ws = 0; ws < 4; ws++) begin
			bus(1'b1, 1'b1, WIN2_END_HI, {ws[1:0], 4'h3, 2'h3});
			bus(1'b1, 1'b1, WIN2_OFF_LO, 8'h10);
			acc(1'b1, 1'b1, 12'h320, ws * WS, 1'b1, 14'h430);
		end
		acc(1'b1, 1'b0, 12'h320, 0, 1'b1, 14'h430);
		bus(1'b1, 1'b1, WIN2_END_HI, 8'h03);
		acc(1'b1, 1'b1, 12'h340, 0, 1'b1, 14'h450);
		acc(1'b1, 1'b1, 12'h341, 0, 1'b0, 14'h0);
		acc(1'b0, 1'b1, 12'h320, 0, 1'b0, 14'h0);
	endtask
	initial begin
		start[1][2] = 12'h300;
		end_lo[1][2] = 8'h40;
		top[1][2] = 6'h01;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 1'b1, WIN4_OFF_LO, 8'h00);
		chk("reset_value", 14'h0, rdata);
		t_map();
		t_unmapped();
		t_access();
		stop_test();
	end
endmodule
`default_nettype wire

// ---- cmw_win_match.sv ----
// Window hit search and host-to-card page translation for one card's windows.
`timescale 1ns/100ps
`default_nettype none
module cmw_win_match (
	input  wire logic [11:0]                       host_page,
	input  wire logic [cmw_pkg::NUM_WIN-1:0][11:0] start_page,
	input  wire logic [cmw_pkg::NUM_WIN-1:0][7:0]  end_hi,
	input  wire logic [cmw_pkg::NUM_WIN-1:0][7:0]  end_lo,
	input  wire logic [cmw_pkg::NUM_WIN-1:0][7:0]  off_lo,
	input  wire logic [cmw_pkg::NUM_WIN-1:0][5:0]  off_top,
	output logic                                   hit,
	output logic [2:0]                             win,
	output logic [13:0]                            card_page,
	output logic [1:0]                             wait_count
);
	import cmw_pkg::*;

	// Lowest-numbered window wins when windows overlap, so software sees a fixed priority.
	always_comb begin
		logic [11:0] end_page;
		logic [13:0] offset;
		end_page = 12'h000;
		offset = 14'h0000;
		hit = 1'b0;
		win = 3'h0;
		card_page = 14'h0000;
		wait_count = 2'h0;
		for (int i = NUM_WIN - 1; i >= 0; i--) begin
			end_page = {end_hi[i][NIBBLE_MSB:0], end_lo[i]}; // R3 R7
			offset = {off_top[i], off_lo[i]}; // R4 R8
			if (host_page >= start_page[i] && host_page <= end_page) begin
				hit = 1'b1;
				win = 3'(i);
				card_page = 14'({2'h0, host_page} + offset); // R4
				wait_count = end_hi[i][WAIT_MSB:WAIT_LSB];
			end
		end
	end
endmodule
`default_nettype wire
